/* File: logic/lssv_core.sv */
// Purpose: Legacy system-state registers, checks and flag traps
// Assumes: APB slave on CLK_SYS, synchronous active-high RESET
// Notes: Instruction inputs come from the same clock domain
//
// Operation
// RULE1: Legacy segment loads unscramble the memory descriptor before storing.
// RULE2: Native descriptor writes are stored without any field check.
// RULE3: Port instructions check the bitmap only when permission check is enabled.
// RULE4: Task state descriptor never drives task switches or privilege transfers.
// RULE5: No interrupt vector table register exists.
// RULE6: Privilege checks and saves use current level, not stack-segment field.
// RULE7: Flags at bits 0-21; upper reserved zero; bit 1 one; 3,5,15 zero.
// RULE8: Legacy flags never alter native instruction execution.
// RULE9: Alignment, step, resume, virtual and mode flags govern legacy execution only.
// RULE10: Legacy attempts to change the nested task flag are intercepted.
// RULE11: Legacy interrupts need global enable and passthrough clear or guest flag.
// RULE12: Native interrupts follow the global enable alone.
// RULE13: Guest flag change by clear, set or pop with notify raises trap.
// RULE14: Descriptor table accesses use no supervisor override.
// RULE15: Interrupt-flag virtualization is independent of virtual-8086 extensions.
// RULE16: Software loads a valid task state descriptor before enabling port checks.
// RULE17: Software initialises descriptor table registers before legacy segment loads.
// RULE18: Flag trap comes after the instruction, with previous flags and vector 2.
// RULE19: Passthrough, notify and port check enable live in the control register.
// RULE20: Reserved flag bits always read zero.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module lssv_core (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Execution state
   input wire logic LEGACY_MODE,
   input wire logic GLOBAL_INTERRUPT_ENABLE,
   input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
   input wire logic [1:0] STACK_SEGMENT_PRIVILEGE_FIELD,
   input wire logic VIRTUAL_8086_MODE_EXTENSIONS,
   // Legacy segment load
   input wire logic SEG_LOAD_VALID,
   input wire logic [1:0] SEG_LOAD_SEL,
   input wire logic [63:0] SEG_LOAD_MEM,
   // Legacy flag instruction
   input lssv_pkg::lssv_instr_t FLAG_INSTR,
   input wire logic NT_WRITE_ATTEMPT,
   // Port access
   input lssv_pkg::lssv_port_t PORT_REQ,
   // Results
   output logic INTR_ENABLE,
   output lssv_pkg::lssv_trap_t TRAP,
   output logic NT_INTERCEPT,
   output logic PORT_BITMAP_CHECK,
   output logic [1:0] CHECK_PRIVILEGE,
   output logic TABLE_SUPERVISOR_OVERRIDE,
   output lssv_pkg::lssv_desc_t TASK_STATE_DESCRIPTOR_REG_OUT
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [63:0] flags;
      logic [34:0] ctrl;
      logic [63:0] task_state_descriptor_reg;
      logic [63:0] global_descriptor_table;
      logic [63:0] local_descriptor_table;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      lssv_pkg::lssv_trap_t trap;
      logic nt_int;
      logic port_chk;
      logic [1:0] chk_priv;
   } lssv_state_t;

   lssv_state_t st_ff;
   lssv_state_t nxt_st;
   lssv_pkg::lssv_desc_t unscr;
   logic [63:0] flag_new;
   logic gate_out;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [63:0] lssv_flag_fix(input logic [63:0] v);
      lssv_flag_fix = (v & lssv_pkg::FLG_WMASK) | lssv_pkg::FLG_ONES; // see RULE7 see RULE20
   endfunction : lssv_flag_fix

   function automatic logic [63:0] lssv_wr_lo(input logic [63:0] r, input logic [31:0] d);
      lssv_wr_lo = {r[63:32], d};
   endfunction : lssv_wr_lo

   function automatic logic [63:0] lssv_wr_hi(input logic [63:0] r, input logic [31:0] d);
      lssv_wr_hi = {d, r[31:0]};
   endfunction : lssv_wr_hi

   function automatic logic lssv_mapped(input logic [7:0] a);
      unique case (a)
         lssv_pkg::OFF_FLAGS_LO, lssv_pkg::OFF_FLAGS_HI, lssv_pkg::OFF_CTRL,
         lssv_pkg::OFF_STATUS, lssv_pkg::OFF_TASK_STATE_DESCRIPTOR_REG_LO, lssv_pkg::OFF_TASK_STATE_DESCRIPTOR_REG_HI,
         lssv_pkg::OFF_GDT_LO, lssv_pkg::OFF_GDT_HI, lssv_pkg::OFF_LDT_LO,
         lssv_pkg::OFF_LDT_HI, lssv_pkg::OFF_CPL, lssv_pkg::OFF_TRAP_FLAGS:
            lssv_mapped = 1'b1;
         default: lssv_mapped = 1'b0;
      endcase
   endfunction : lssv_mapped

   // ****************************************
   // Submodules
   // ****************************************
   lssv_unscramble u_unscr (
      .mem_desc(SEG_LOAD_MEM),
      .reg_desc(unscr)
   );

   lssv_intr_gate u_gate (
      .legacy_mode(LEGACY_MODE),
      .global_interrupt_enable(GLOBAL_INTERRUPT_ENABLE),
      .interrupt_flag_passthrough(st_ff.ctrl[lssv_pkg::CTRL_IF_BIT]),
      .guest_interrupt_flag(st_ff.flags[lssv_pkg::FLG_IF]),
      .intr_enable(gate_out)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt_st = st_ff;
      flag_new = st_ff.flags;
      nxt_st.trap.valid = 1'b0;
      nxt_st.nt_int = 1'b0;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;

      // Flag instruction, effect and trap after completion
      if (FLAG_INSTR.valid && LEGACY_MODE && FLAG_INSTR.priv_ok) // see RULE9
      begin
         unique case (FLAG_INSTR.op)
            lssv_pkg::OP_CLEAR: flag_new[lssv_pkg::FLG_IF] = 1'b0;
            lssv_pkg::OP_SET: flag_new[lssv_pkg::FLG_IF] = 1'b1;
            lssv_pkg::OP_POP:
            begin
               flag_new = {st_ff.flags[63:32], FLAG_INSTR.data};
               flag_new[lssv_pkg::FLG_NT] = st_ff.flags[lssv_pkg::FLG_NT]; // see RULE10
            end
            lssv_pkg::OP_NONE: flag_new = st_ff.flags;
         endcase
         flag_new = lssv_flag_fix(flag_new);
         nxt_st.flags = flag_new;
         if (st_ff.ctrl[lssv_pkg::CTRL_II_BIT]
            && flag_new[lssv_pkg::FLG_IF] != st_ff.flags[lssv_pkg::FLG_IF]) // see RULE13
         begin
            nxt_st.trap.valid = 1'b1; // see RULE18
            nxt_st.trap.vector = lssv_pkg::TRAP_VEC_SYSFLAG;
            nxt_st.trap.prev_flags = st_ff.flags;
         end
      end

      // Nested task modification never completes
      if (NT_WRITE_ATTEMPT && LEGACY_MODE)
      begin
         nxt_st.nt_int = 1'b1; // see RULE10
      end

      // Legacy segment load stores unscrambled form
      if (SEG_LOAD_VALID && LEGACY_MODE)
      begin
         unique case (SEG_LOAD_SEL)
            2'h0: nxt_st.global_descriptor_table = {1'b0, unscr}; // see RULE1
            2'h1: nxt_st.local_descriptor_table = {1'b0, unscr}; // see RULE1
            2'h2: nxt_st.task_state_descriptor_reg = {1'b0, unscr}; // see RULE1
            default: nxt_st.task_state_descriptor_reg = st_ff.task_state_descriptor_reg;
         endcase
      end

      // Port permission check enable
      nxt_st.port_chk = PORT_REQ.valid && LEGACY_MODE
         && st_ff.ctrl[lssv_pkg::CTRL_IO_BIT]; // see RULE3

      // Privilege source for checks
      nxt_st.chk_priv = CURRENT_PRIVILEGE_LEVEL; // see RULE6

      // APB access, one wait state before PREADY
      if (PSEL && !PENABLE)
      begin
         nxt_st.prdata = 32'h00000000;
      end
      if (PSEL && PENABLE && !st_ff.pready)
      begin
         nxt_st.pready = 1'b1;
         nxt_st.pslverr = ~lssv_mapped(PADDR); // see RULE5
         if (PWRITE)
         begin
            unique case (PADDR)
               lssv_pkg::OFF_FLAGS_LO:
               begin
                  nxt_st.flags = lssv_flag_fix(lssv_wr_lo(nxt_st.flags, PWDATA));
               end
               lssv_pkg::OFF_FLAGS_HI:
               begin
                  nxt_st.flags = lssv_flag_fix(lssv_wr_hi(nxt_st.flags, PWDATA));
               end
               lssv_pkg::OFF_CTRL:
               begin
                  nxt_st.ctrl[31:0] = PWDATA;
               end
               lssv_pkg::OFF_STATUS:
               begin
                  nxt_st.ctrl[34:32] = PWDATA[2:0]; // see RULE19
               end
               lssv_pkg::OFF_TASK_STATE_DESCRIPTOR_REG_LO:
               begin
                  nxt_st.task_state_descriptor_reg = lssv_wr_lo(nxt_st.task_state_descriptor_reg, PWDATA); // see RULE2
               end
               lssv_pkg::OFF_TASK_STATE_DESCRIPTOR_REG_HI:
               begin
                  nxt_st.task_state_descriptor_reg = lssv_wr_hi(nxt_st.task_state_descriptor_reg, PWDATA); // see RULE2
               end
               lssv_pkg::OFF_GDT_LO:
               begin
                  nxt_st.global_descriptor_table = lssv_wr_lo(nxt_st.global_descriptor_table, PWDATA); // see RULE2
               end
               lssv_pkg::OFF_GDT_HI:
               begin
                  nxt_st.global_descriptor_table = lssv_wr_hi(nxt_st.global_descriptor_table, PWDATA); // see RULE2
               end
               lssv_pkg::OFF_LDT_LO:
               begin
                  nxt_st.local_descriptor_table = lssv_wr_lo(nxt_st.local_descriptor_table, PWDATA); // see RULE2
               end
               lssv_pkg::OFF_LDT_HI:
               begin
                  nxt_st.local_descriptor_table = lssv_wr_hi(nxt_st.local_descriptor_table, PWDATA); // see RULE2
               end
               lssv_pkg::OFF_CPL, lssv_pkg::OFF_TRAP_FLAGS:
               begin
                  nxt_st.pslverr = 1'b0;
               end
               default:
               begin
                  nxt_st.pslverr = 1'b1;
               end
            endcase
         end
         else
         begin
            unique case (PADDR)
               lssv_pkg::OFF_FLAGS_LO:
               begin
                  nxt_st.prdata = st_ff.flags[31:0];
               end
               lssv_pkg::OFF_FLAGS_HI:
               begin
                  nxt_st.prdata = st_ff.flags[63:32]; // see RULE20
               end
               lssv_pkg::OFF_CTRL:
               begin
                  nxt_st.prdata = st_ff.ctrl[31:0];
               end
               lssv_pkg::OFF_STATUS:
               begin
                  nxt_st.prdata = {29'h00000000, st_ff.ctrl[34:32]};
               end
               lssv_pkg::OFF_TASK_STATE_DESCRIPTOR_REG_LO:
               begin
                  nxt_st.prdata = st_ff.task_state_descriptor_reg[31:0];
               end
               lssv_pkg::OFF_TASK_STATE_DESCRIPTOR_REG_HI:
               begin
                  nxt_st.prdata = st_ff.task_state_descriptor_reg[63:32];
               end
               lssv_pkg::OFF_GDT_LO:
               begin
                  nxt_st.prdata = st_ff.global_descriptor_table[31:0];
               end
               lssv_pkg::OFF_GDT_HI:
               begin
                  nxt_st.prdata = st_ff.global_descriptor_table[63:32];
               end
               lssv_pkg::OFF_LDT_LO:
               begin
                  nxt_st.prdata = st_ff.local_descriptor_table[31:0];
               end
               lssv_pkg::OFF_LDT_HI:
               begin
                  nxt_st.prdata = st_ff.local_descriptor_table[63:32];
               end
               lssv_pkg::OFF_CPL:
               begin
                  nxt_st.prdata = {30'h00000000, st_ff.chk_priv};
               end
               lssv_pkg::OFF_TRAP_FLAGS:
               begin
                  nxt_st.prdata = st_ff.trap.prev_flags[31:0];
               end
               default:
               begin
                  nxt_st.prdata = 32'h00000000;
                  nxt_st.pslverr = 1'b1;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         st_ff <= '0;
         st_ff.flags <= lssv_pkg::FLG_RESET;
         st_ff.ctrl <= lssv_pkg::CTRL_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb
   begin
      PRDATA = st_ff.prdata;
      PREADY = st_ff.pready;
      PSLVERR = st_ff.pslverr;
      INTR_ENABLE = gate_out; // see RULE8 see RULE15
      TRAP = st_ff.trap;
      NT_INTERCEPT = st_ff.nt_int;
      PORT_BITMAP_CHECK = st_ff.port_chk; // see RULE3
      CHECK_PRIVILEGE = st_ff.chk_priv; // see RULE6
      TABLE_SUPERVISOR_OVERRIDE = 1'b0; // see RULE14
      TASK_STATE_DESCRIPTOR_REG_OUT = st_ff.task_state_descriptor_reg[62:0]; // see RULE4
   end

endmodule : lssv_core

/* File: logic/lssv_intr_gate.sv */
// Purpose: Effective interrupt enable for native and legacy execution
// Assumes: Inputs from same clock domain
// Notes: Independent of virtual-8086 extensions
`timescale 1ns/1ps
module lssv_intr_gate (
   // Mode and enables
   input wire logic legacy_mode,
   input wire logic global_interrupt_enable,
   input wire logic interrupt_flag_passthrough,
   input wire logic guest_interrupt_flag,
   // Result
   output logic intr_enable
);

   // ****************************************
   // Enable equation
   // ****************************************
   always_comb
   begin
      if (legacy_mode)
      begin
         intr_enable = global_interrupt_enable
            & (~interrupt_flag_passthrough | guest_interrupt_flag); // see RULE11
      end
      else
      begin
         intr_enable = global_interrupt_enable; // see RULE12
      end
   end

endmodule : lssv_intr_gate

/* File: logic/lssv_pkg.sv */
// Purpose: Shared constants and carriers for the legacy system-state block
// Assumes: APB slave, 32-bit data, wide registers split over two words
// Notes: All offsets are byte addresses
package lssv_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFF_FLAGS_LO = 8'h00;
   localparam logic [7:0] OFF_FLAGS_HI = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_TASK_STATE_DESCRIPTOR_REG_LO = 8'h0C;
   localparam logic [7:0] OFF_TASK_STATE_DESCRIPTOR_REG_HI = 8'h10;
   localparam logic [7:0] OFF_GDT_LO = 8'h14;
   localparam logic [7:0] OFF_GDT_HI = 8'h18;
   localparam logic [7:0] OFF_LDT_LO = 8'h1C;
   localparam logic [7:0] OFF_LDT_HI = 8'h20;
   localparam logic [7:0] OFF_CPL = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_TRAP_FLAGS = 8'h2C;

   // ****************************************
   // Control register field positions
   // ****************************************
   localparam int CTRL_IO_BIT = 32;
   localparam int CTRL_IF_BIT = 33;
   localparam int CTRL_II_BIT = 34;
   localparam int CTRL_W = 35;
   localparam logic [34:0] CTRL_RESET = 35'h000000000;

   // ****************************************
   // Legacy flags layout
   // ****************************************
   localparam int FLG_TF = 8;
   localparam int FLG_IF = 9;
   localparam int FLG_NT = 14;
   localparam logic [63:0] FLG_WMASK = 64'h00000000003F7FD5;
   localparam logic [63:0] FLG_ONES = 64'h0000000000000002;
   localparam logic [63:0] FLG_RESET = 64'h0000000000000002;

   // ****************************************
   // Trap vector and instruction codes
   // ****************************************
   localparam logic [3:0] TRAP_VEC_SYSFLAG = 4'h2;
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_CLEAR = 2'h1;
   localparam logic [1:0] OP_SET = 2'h2;
   localparam logic [1:0] OP_POP = 2'h3;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [31:0] base;
      logic [19:0] limit;
      logic [3:0] seg_type;
      logic sys;
      logic [1:0] dpl;
      logic present;
      logic avl;
      logic big;
      logic gran;
   } lssv_desc_t;

   typedef struct packed {
      logic valid;
      logic [1:0] op;
      logic [31:0] data;
      logic priv_ok;
   } lssv_instr_t;

   typedef struct packed {
      logic valid;
      logic [3:0] vector;
      logic [63:0] prev_flags;
   } lssv_trap_t;

   typedef struct packed {
      logic valid;
      logic [15:0] port;
      logic [2:0] size;
   } lssv_port_t;

endpackage : lssv_pkg

/* File: logic/lssv_unscramble.sv */
// Purpose: Converts a scrambled descriptor-table entry into register format
// Assumes: Standard 8-byte memory descriptor layout
// Notes: Purely combinational
`timescale 1ns/1ps
module lssv_unscramble (
   // Memory image
   input wire logic [63:0] mem_desc,
   // Register image
   output lssv_pkg::lssv_desc_t reg_desc
);

   // ****************************************
   // Field gathering
   // ****************************************
   always_comb
   begin
      reg_desc.limit = {mem_desc[51:48], mem_desc[15:0]};
      reg_desc.base = {mem_desc[63:56], mem_desc[39:16]};
      reg_desc.seg_type = mem_desc[43:40];
      reg_desc.sys = mem_desc[44];
      reg_desc.dpl = mem_desc[46:45];
      reg_desc.present = mem_desc[47];
      reg_desc.avl = mem_desc[52];
      reg_desc.big = mem_desc[54];
      reg_desc.gran = mem_desc[55];
   end

endmodule : lssv_unscramble

/* File: tb/lssv_core_tb.sv */
// Purpose: Self-checking bench for the legacy system-state block
// Assumes: 10 MHz clock, reset held 10 cycles
// Notes: Register access over APB tasks
`timescale 1ns/1ps
module lssv_core_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic CLK_SYS = 1'h0;
   logic RESET = 1'h1;
   logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PREADY, PSLVERR;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic LEGACY_MODE = 1'h0, GLOBAL_INTERRUPT_ENABLE = 1'h0, VIRTUAL_8086_MODE_EXTENSIONS = 1'h0;
   logic SEG_LOAD_VALID = 1'h0, NT_WRITE_ATTEMPT = 1'h0;
   logic [1:0] CURRENT_PRIVILEGE_LEVEL = 2'h0, STACK_SEGMENT_PRIVILEGE_FIELD = 2'h0;
   logic [1:0] SEG_LOAD_SEL = 2'h3, CHECK_PRIVILEGE;
   logic [63:0] SEG_LOAD_MEM = 64'h0;
   logic INTR_ENABLE, NT_INTERCEPT, PORT_BITMAP_CHECK, TABLE_SUPERVISOR_OVERRIDE;
   lssv_pkg::lssv_instr_t FLAG_INSTR = '0;
   lssv_pkg::lssv_port_t PORT_REQ = '0;
   lssv_pkg::lssv_trap_t TRAP;
   lssv_pkg::lssv_desc_t TASK_STATE_DESCRIPTOR_REG_OUT;
   int failures = 0;
   int checks = 0;
   logic [31:0] rd;
   logic err;

   always #50 CLK_SYS = ~CLK_SYS;

   lssv_core lssv_core_inst (
      .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .LEGACY_MODE(LEGACY_MODE), .GLOBAL_INTERRUPT_ENABLE(GLOBAL_INTERRUPT_ENABLE),
      .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL),
      .STACK_SEGMENT_PRIVILEGE_FIELD(STACK_SEGMENT_PRIVILEGE_FIELD),
      .VIRTUAL_8086_MODE_EXTENSIONS(VIRTUAL_8086_MODE_EXTENSIONS),
      .SEG_LOAD_VALID(SEG_LOAD_VALID), .SEG_LOAD_SEL(SEG_LOAD_SEL), .SEG_LOAD_MEM(SEG_LOAD_MEM),
      .FLAG_INSTR(FLAG_INSTR), .NT_WRITE_ATTEMPT(NT_WRITE_ATTEMPT), .PORT_REQ(PORT_REQ),
      .INTR_ENABLE(INTR_ENABLE), .TRAP(TRAP), .NT_INTERCEPT(NT_INTERCEPT),
      .PORT_BITMAP_CHECK(PORT_BITMAP_CHECK), .CHECK_PRIVILEGE(CHECK_PRIVILEGE),
      .TABLE_SUPERVISOR_OVERRIDE(TABLE_SUPERVISOR_OVERRIDE), .TASK_STATE_DESCRIPTOR_REG_OUT(TASK_STATE_DESCRIPTOR_REG_OUT)
   );

   // ****************************************
   // Tasks
   // ****************************************
   task complete_run;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge CLK_SYS);
      PSEL <= 1'h1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1'h1;
      do
      begin
         @(posedge CLK_SYS);
         n++;
      end
      while (PREADY !== 1'h1 && n < 20);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      if (PREADY !== 1'h1)
      begin
         failures++;
         complete_run();
      end
   endtask : apb

   task flag_op(input logic [1:0] op, input logic ok, input logic tv, input logic [63:0] prev);
      @(posedge CLK_SYS);
      FLAG_INSTR <= {1'h1, op, 32'h0, ok};
      @(posedge CLK_SYS);
      FLAG_INSTR <= '0;
      #1;
      chk(TRAP.valid, tv);
      if (tv)
         chk(TRAP.prev_flags, prev);
   endtask : flag_op

   task pulse(input logic att, input logic en_att, input logic en_chk);
      @(posedge CLK_SYS);
      NT_WRITE_ATTEMPT <= att;
      PORT_REQ <= {1'h1, 16'h0060, 3'h1};
      @(posedge CLK_SYS);
      NT_WRITE_ATTEMPT <= 1'h0;
      PORT_REQ <= '0;
      #1;
      chk(NT_INTERCEPT, en_att);
      chk(PORT_BITMAP_CHECK, en_chk);
   endtask : pulse

   task mode(input logic leg);
      @(posedge CLK_SYS);
      LEGACY_MODE <= leg;
   endtask : mode

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (10) @(posedge CLK_SYS);
      RESET <= 1'h0;
      apb(1'h0, 8'h00, 32'h0); chk(rd, 32'h2);
      apb(1'h0, 8'h04, 32'h0); chk(rd, 32'h0);
      apb(1'h0, 8'h28, 32'h0); chk(rd, 32'h0);
      chk(TABLE_SUPERVISOR_OVERRIDE, 1'h0);
      $display("test reset done");
      apb(1'h1, 8'h00, 32'hFFFFFFFF); apb(1'h0, 8'h00, 32'h0); chk(rd, 32'h003F7FD7);
      apb(1'h1, 8'h04, 32'hFFFFFFFF); apb(1'h0, 8'h04, 32'h0); chk(rd, 32'h0);
      apb(1'h0, 8'h40, 32'h0); chk({err, rd}, 33'h100000000);
      $display("test flags layout done");
      for (int i = 0; i < 32; i++)
      begin
         apb(1'h1, 8'h28, {30'h0, i[2], 1'h0});
         apb(1'h1, 8'h00, i[3] ? 32'h202 : 32'h2);
         @(posedge CLK_SYS);
         LEGACY_MODE <= i[0];
         GLOBAL_INTERRUPT_ENABLE <= i[1];
         VIRTUAL_8086_MODE_EXTENSIONS <= i[4];
         @(posedge CLK_SYS);
         #1;
         chk(INTR_ENABLE, i[0] ? (i[1] && (!i[2] || i[3])) : i[1]);
      end
      $display("test interrupt enable done");
      apb(1'h1, 8'h28, 32'h4);
      apb(1'h1, 8'h00, 32'h202);
      mode(1'h1);
      flag_op(lssv_pkg::OP_CLEAR, 1'h1, 1'h1, 64'h202);
      flag_op(lssv_pkg::OP_CLEAR, 1'h1, 1'h0, 64'h0);
      flag_op(lssv_pkg::OP_SET, 1'h0, 1'h0, 64'h0);
      flag_op(lssv_pkg::OP_SET, 1'h1, 1'h1, 64'h2);
      flag_op(lssv_pkg::OP_POP, 1'h1, 1'h1, 64'h202);
      apb(1'h0, 8'h00, 32'h0); chk(rd, 32'h2);
      apb(1'h1, 8'h28, 32'h0);
      flag_op(lssv_pkg::OP_SET, 1'h1, 1'h0, 64'h0);
      apb(1'h1, 8'h28, 32'h4);
      mode(1'h0);
      flag_op(lssv_pkg::OP_CLEAR, 1'h1, 1'h0, 64'h0);
      apb(1'h0, 8'h00, 32'h0); chk(rd, 32'h202);
      $display("test flag traps done");
      apb(1'h1, 8'h0C, 32'h00033888);
      apb(1'h1, 8'h10, 32'h00000000);
      apb(1'h1, 8'h28, 32'h1);
      mode(1'h1);
      pulse(1'h1, 1'h1, 1'h1);
      apb(1'h1, 8'h28, 32'h0);
      pulse(1'h0, 1'h0, 1'h0);
      apb(1'h1, 8'h28, 32'h1);
      mode(1'h0);
      pulse(1'h1, 1'h0, 1'h0);
      $display("test intercepts done");
      @(posedge CLK_SYS);
      CURRENT_PRIVILEGE_LEVEL <= 2'h3;
      STACK_SEGMENT_PRIVILEGE_FIELD <= 2'h1;
      apb(1'h0, 8'h24, 32'h0); chk(rd, 32'h3);
      chk(CHECK_PRIVILEGE, 2'h3);
      apb(1'h1, 8'h14, 32'h00000000);
      apb(1'h1, 8'h1C, 32'h00000000);
      @(posedge CLK_SYS);
      LEGACY_MODE <= 1'h1;
      SEG_LOAD_VALID <= 1'h1;
      SEG_LOAD_SEL <= 2'h2;
      SEG_LOAD_MEM <= 64'h12CBE9345678ABCD;
      @(posedge CLK_SYS);
      SEG_LOAD_VALID <= 1'h0;
      @(posedge CLK_SYS);
      #1;
      chk(TASK_STATE_DESCRIPTOR_REG_OUT.base, 32'h12345678);
      chk({TASK_STATE_DESCRIPTOR_REG_OUT.limit, TASK_STATE_DESCRIPTOR_REG_OUT.dpl, TASK_STATE_DESCRIPTOR_REG_OUT.present}, 23'h5D5E6F);
      apb(1'h1, 8'h0C, 32'hDEADBEEF); apb(1'h0, 8'h0C, 32'h0); chk(rd, 32'hDEADBEEF);
      $display("test privilege and descriptors done");
      complete_run();
   end
endmodule : lssv_core_tb

/* File: tb/lssv_props.sv */
// Purpose: Port-level properties of the legacy system-state block
// Assumes: One clock domain, synchronous active-high RESET
// Notes: Bound to lssv_core after the module
`timescale 1ns/1ps
module lssv_props (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Register bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Execution state
   input wire logic LEGACY_MODE,
   input wire logic GLOBAL_INTERRUPT_ENABLE,
   input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
   input lssv_pkg::lssv_instr_t FLAG_INSTR,
   input wire logic NT_WRITE_ATTEMPT,
   input lssv_pkg::lssv_port_t PORT_REQ,
   // Results
   input wire logic INTR_ENABLE,
   input lssv_pkg::lssv_trap_t TRAP,
   input wire logic NT_INTERCEPT,
   input wire logic PORT_BITMAP_CHECK,
   input wire logic [1:0] CHECK_PRIVILEGE,
   input wire logic TABLE_SUPERVISOR_OVERRIDE
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   sequence s_taken;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_answer;
      PREADY ##1 !PREADY;
   endsequence

   a_apb_answer: assert property (s_taken |=> s_answer)
      else $error("bus answer late or not a pulse");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("bus error without ready");
   a_native_intr: assert property (!LEGACY_MODE |-> INTR_ENABLE == GLOBAL_INTERRUPT_ENABLE)
      else $error("native interrupt enable wrong");
   a_no_override: assert property (TABLE_SUPERVISOR_OVERRIDE == 1'h0)
      else $error("table override set");
   a_priv_copy: assert property (1'h1 |=> CHECK_PRIVILEGE == $past(CURRENT_PRIVILEGE_LEVEL))
      else $error("privilege source wrong");
   a_nested_catch: assert property (NT_WRITE_ATTEMPT && LEGACY_MODE |=> NT_INTERCEPT)
      else $error("nested task change not intercepted");
   a_port_cause: assert property (PORT_BITMAP_CHECK |-> $past(PORT_REQ.valid) && $past(LEGACY_MODE))
      else $error("bitmap check without legacy port access");
   a_trap_code: assert property (TRAP.valid |-> TRAP.vector == lssv_pkg::TRAP_VEC_SYSFLAG)
      else $error("trap vector wrong");
   a_trap_cause: assert property (TRAP.valid |-> $past(FLAG_INSTR.valid) && $past(LEGACY_MODE))
      else $error("trap without legacy flag instruction");
endmodule : lssv_props

bind lssv_core lssv_props lssv_props_inst (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .LEGACY_MODE(LEGACY_MODE), .GLOBAL_INTERRUPT_ENABLE(GLOBAL_INTERRUPT_ENABLE),
   .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .FLAG_INSTR(FLAG_INSTR),
   .NT_WRITE_ATTEMPT(NT_WRITE_ATTEMPT), .PORT_REQ(PORT_REQ), .INTR_ENABLE(INTR_ENABLE),
   .TRAP(TRAP), .NT_INTERCEPT(NT_INTERCEPT), .PORT_BITMAP_CHECK(PORT_BITMAP_CHECK),
   .CHECK_PRIVILEGE(CHECK_PRIVILEGE), .TABLE_SUPERVISOR_OVERRIDE(TABLE_SUPERVISOR_OVERRIDE)
);
